// file: logic/psvw_prog_rom.v
/*
 Program memory model: 24-bit words, registered read data.
 Assumes one read per cycle; contents loaded by a write port.
*/
module psvw_prog_rom #(
    parameter AW = 23,
    parameter DEPTH_AW = 10
) (
    input wire clk,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [23:0] rd_data,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [23:0] wr_data
);
    reg [23:0] mem [0:(1<<DEPTH_AW)-1];

    // Only the low index bits are stored; higher pages alias
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr[DEPTH_AW-1:0]] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr[DEPTH_AW-1:0]];
        end
    end
endmodule

// file: logic/psvw_window.v
/*
 Program space data window: maps core data reads at 8000h and up
 onto program memory pages, with stall generation.
 Assumes the core holds a load request while stall is high and
 supplies the instruction class and table-access busy level.
*/
`include "psvw_map.vh"

module psvw_window #(
    parameter PAGE_W = 8,
    parameter EA_W = 16,
    parameter DEPTH_AW = 10
) (
    input wire clk,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Core load path
    input wire ld_req,
    input wire [EA_W-1:0] effective_addr,
    input wire ld_is_move,
    input wire table_busy,
    output wire ld_stall,
    output reg ld_done,
    output reg [15:0] ld_data,
    output reg ld_from_prog,
    // Data memory path
    output wire dmem_rd,
    output wire [EA_W-1:0] dmem_addr,
    input wire [15:0] dmem_rdata,
    // Program memory loader
    input wire prog_wr,
    input wire [PAGE_W+EA_W-2:0] prog_waddr,
    input wire [23:0] prog_wdata
);
    localparam PA_W = PAGE_W + EA_W - 1;
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [PAGE_W-1:0] program_page_select;
    reg [15:0] core_control_reg;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] wait_cnt;
    reg [1:0] next_wait_cnt;
    reg [15:0] window_reads;
    wire program_view_enable;
    wire in_window;
    wire win_hit;
    wire [PA_W-1:0] prog_addr;
    wire [23:0] prog_word;
    wire prog_rd;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    assign program_view_enable = core_control_reg[`PSVW_VIEW_EN_BIT];

    always @(posedge clk) begin
        if (!resetn) begin
            program_page_select <= `PSVW_PAGE_RESET;
            core_control_reg <= `PSVW_CTRL_RESET;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `PSVW_OFF_PAGE) begin
                program_page_select <= reg_wdata[PAGE_W-1:0];
            end
            if (reg_wr && reg_addr == `PSVW_OFF_CORE_CTRL) begin
                core_control_reg <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `PSVW_OFF_PAGE: reg_rdata <= {{(16-PAGE_W){1'b0}}, program_page_select};
                    `PSVW_OFF_CORE_CTRL: reg_rdata <= core_control_reg;
                    `PSVW_OFF_STATUS: reg_rdata <= window_reads;
                    default: reg_rdata <= 16'h0000;
                endcase
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign in_window = effective_addr[`PSVW_EA_TOP_BIT];
    assign win_hit = ld_req && in_window && program_view_enable;
    // Page over the low EA bits; byte and word addresses line up
    assign prog_addr = {program_page_select, effective_addr[`PSVW_EA_LOW_MSB:0]};
    // Table accesses own program memory, so the window holds off
    assign prog_rd = win_hit && !table_busy && state == ST_IDLE;

    // Ordinary data path answers in the same cycle
    assign dmem_rd = ld_req && !win_hit && state == ST_IDLE;
    assign dmem_addr = effective_addr;

    psvw_prog_rom #(
        .AW(PA_W),
        .DEPTH_AW(DEPTH_AW)
    ) u_rom (
        .clk(clk),
        .rd_en(prog_rd),
        .rd_addr(prog_addr),
        .rd_data(prog_word),
        .wr_en(prog_wr),
        .wr_addr(prog_waddr),
        .wr_data(prog_wdata)
    );

    // ------------------------------------------------------------
    // Stall sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        case (state)
            ST_IDLE: begin
                if (prog_rd) begin
                    next_state = ST_WAIT;
                    next_wait_cnt = ld_is_move ? `PSVW_EXTRA_MOVE : `PSVW_EXTRA_OTHER;
                end
            end
            ST_WAIT: begin
                next_wait_cnt = wait_cnt - 2'h1;
                if (wait_cnt == 2'h1) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Stall while waiting for table access or counting extra cycles
    assign ld_stall = (win_hit && state == ST_IDLE) || state == ST_WAIT;

    // ------------------------------------------------------------
    // Load answer
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            wait_cnt <= 2'h0;
            ld_done <= 1'b0;
            ld_data <= 16'h0000;
            ld_from_prog <= 1'b0;
            window_reads <= 16'h0000;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            ld_done <= 1'b0;
            if (dmem_rd) begin
                ld_done <= 1'b1;
                ld_data <= dmem_rdata;
                ld_from_prog <= 1'b0;
            end else if (state == ST_WAIT && wait_cnt == 2'h1) begin
                ld_done <= 1'b1;
                ld_data <= prog_word[`PSVW_DATA_LOW_MSB:0];
                ld_from_prog <= 1'b1;
                window_reads <= window_reads + 16'h0001;
            end
        end
    end
endmodule

// file: pkg/psvw_map.vh
/*
 Address map and timing constants for the program space data window.
 Assumes inclusion by the window logic only; definitions only.
*/
`ifndef PSVW_MAP_VH
`define PSVW_MAP_VH

// ------------------------------------------------------------
// Register port offsets
// ------------------------------------------------------------
`define PSVW_OFF_PAGE 4'h0
`define PSVW_OFF_CORE_CTRL 4'h1
`define PSVW_OFF_STATUS 4'h2

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PSVW_VIEW_EN_BIT 2
`define PSVW_EA_TOP_BIT 15
`define PSVW_EA_LOW_MSB 14
`define PSVW_PAGE_RESET 8'h00
`define PSVW_CTRL_RESET 16'h0000
`define PSVW_DATA_LOW_MSB 15

// ------------------------------------------------------------
// Extra cycles
// ------------------------------------------------------------
`define PSVW_EXTRA_MOVE 2'h1
`define PSVW_EXTRA_OTHER 2'h2

`endif

// file: verification/psvw_dmem_model.sv
/* Data memory beside the window: read data in the same cycle.
   Assumes the bench applies the same address pattern. */
module psvw_dmem_model (
    input wire dmem_rd,
    input wire [15:0] dmem_addr,
    output logic [15:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Deselected: inverse, so stale data never passes
    assign dmem_rdata = dmem_rd ? dmem_addr ^ 16'h5a3c : ~(dmem_addr ^ 16'h5a3c);
endmodule

// file: verification/psvw_window_chk.sv
/* Load path checker for the window.
   Assumes it is bound into psvw_window on one clock. */
module psvw_window_chk #(parameter EA_W = 16) (
    input wire clk,
    input wire resetn,
    input wire ld_req,
    input wire [EA_W-1:0] effective_addr,
    input wire ld_is_move,
    input wire table_busy,
    input wire ld_stall,
    input wire ld_done,
    input wire [15:0] ld_data,
    input wire dmem_rd,
    input wire [15:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic req_q;
    always @(posedge clk) req_q <= ld_req;
    wire start = ld_req && !req_q;
    wire win_go = start && ld_stall && !table_busy;
    // ----
    // Load timing, source and data
    // ----
    a_plain_done: assert property (start && !ld_stall |=> ld_done)
        else $error("plain load late");
    a_move_lat: assert property (win_go && ld_is_move |=> !ld_done ##1 ld_done)
        else $error("move window latency");
    a_other_lat: assert property (win_go && !ld_is_move |=> !ld_done [*2] ##1 ld_done)
        else $error("other window latency");
    a_table_wait: assert property (ld_stall && table_busy |=> ld_stall && !ld_done)
        else $error("window ran during table access");
    a_low_half: assert property (ld_req && !ld_done && !effective_addr[EA_W-1]
        |-> dmem_rd && !ld_stall) else $error("low half not from data memory");
    a_stall_cause: assert property (ld_stall |-> ld_req && effective_addr[EA_W-1])
        else $error("stall without window address");
    a_reset_idle: assert property ($rose(resetn) |-> !ld_done && !ld_stall)
        else $error("busy after reset");
    a_dmem_data: assert property (ld_done && $past(dmem_rd) |-> ld_data == $past(dmem_rdata))
        else $error("data memory word lost");
    c_move: cover property (win_go && ld_is_move);
    c_busy: cover property (ld_stall && table_busy);
    c_plain: cover property (start && !ld_stall);
endmodule
bind psvw_window psvw_window_chk #(.EA_W(EA_W)) chk (.clk, .resetn, .ld_req, .effective_addr,
    .ld_is_move, .table_busy, .ld_stall, .ld_done, .ld_data, .dmem_rd, .dmem_rdata);

// file: verification/testbench.sv
/* Self-checking bench for the window.
   Assumes the data memory model and the bound checker. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, reg_wr, reg_rd, ld_req, ld_is_move, table_busy, ld_stall, ld_done;
    logic ld_from_prog, dmem_rd, prog_wr;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, effective_addr, ld_data, dmem_addr, dmem_rdata, pg;
    logic [22:0] prog_waddr;
    logic [23:0] prog_wdata;
    logic [23:0] pm [1024];
    int failures, n_checks, nwin;
    psvw_window dut (.*);
    psvw_dmem_model dmem (.*);
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string s, logic [23:0] e, logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr_rd(logic [3:0] a, logic [15:0] d, logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk("reg", e, reg_rdata);
    endtask
    // ----
    // One core load, table access held off the window at random
    // ----
    task automatic load(logic [15:0] ea, logic mv, logic en);
        logic win, src;
        logic [15:0] got;
        int bz, k, n, lat, end_k;
        win = en && ea[15];
        bz = win ? $urandom % 3 : 0;
        nwin += win;
        k = 0;
        n = 0;
        lat = 0;
        got = '0;
        src = 0;
        end_k = 99;
        @(posedge clk);
        ld_req <= 1;
        effective_addr <= ea;
        ld_is_move <= mv;
        table_busy <= bz > 0;
        // Request is taken in the first cycle without stall; drop it there
        do begin
            #1 if (ld_done === 1'b1) begin
                n++;
                lat = k;
                got = ld_data;
                src = ld_from_prog;
            end
            if (end_k == 99 && ld_stall === 1'b0) end_k = k + 3;
            @(posedge clk);
            k++;
            if (k == bz) table_busy <= 0;
            if (k == end_k - 2) ld_req <= 0;
        end while (k < end_k && k < 16);
        if (end_k == 99) begin
            failures++;
            report_and_stop();
        end
        chk("done count", 1, n);
        chk("latency", win ? bz + 3 - mv : 1, lat);
        chk("data", win ? pm[ea[9:0]][15:0] : ea ^ 16'h5a3c, got);
        chk("source", win, src);
    endtask
    initial begin
        {resetn, reg_wr, reg_rd, ld_req, ld_is_move, table_busy, prog_wr} = '0;
        {reg_addr, reg_wdata, effective_addr, prog_waddr, prog_wdata} = '0;
        nwin = 0;
        void'($urandom(67));
        repeat (6) @(posedge clk);
        resetn <= 1;
        wr_rd(4'h2, 16'hffff, 16'h0000);
        wr_rd(4'h7, 16'hffff, 16'h0000);
        pg = $urandom;
        wr_rd(4'h0, pg, pg & 16'h00ff);
        for (int i = 0; i < 1024; i++) begin
            pm[i] = $urandom;
            @(posedge clk);
            prog_wr <= 1;
            prog_waddr <= {pg[7:0], 15'(i)};
            prog_wdata <= pm[i];
        end
        @(posedge clk);
        prog_wr <= 0;
        for (int en = 0; en < 2; en++) begin
            wr_rd(4'h1, en ? 16'h0004 : 16'h0000, en ? 16'h0004 : 16'h0000);
            repeat (40) load($urandom, $urandom, en[0]);
        end
        wr_rd(4'h2, 16'hffff, nwin[15:0]);
        // Mid-run reset: counter and enable must return to idle
        @(posedge clk);
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        wr_rd(4'h2, 16'hffff, 16'h0000);
        repeat (4) load($urandom, $urandom, 1'b0);
        report_and_stop();
    end
endmodule
